// >>> ea_adder.sv
// Address adder with carry kept to a chosen width and wrapped above it.
module ea_adder
#(
    parameter int WIDTH = 16
)
(
    input  wire logic [WIDTH-1:0] a,
    input  wire logic [WIDTH-1:0] b,
    output logic      [WIDTH-1:0] sum
);
    // The byte-offset carry needs at least nine bits of sum, so narrower adders are refused.
    if (WIDTH < 9)
    begin : g_width_check
        $error("ea_adder: width too small");
    end

    // Carry out of the top bit is dropped so the result wraps.
    assign sum = a + b;
endmodule // ea_adder

// >>> ea_gen.sv
// Indexed and relative operand location generator with pointer and zero flag.
`include "ea_gen_cfg.svh"
module ea_gen
(
    input  wire logic                      SYS_CLK,
    input  wire logic                      RESET,
    input  wire logic                      START,
    input  wire ea_gen_pkg::addr_mode_t    MODE,
    input  wire ea_gen_pkg::instr_class_t  INSTR_CLASS,
    input  wire logic [`ADDR_W-1:0]        INSTR_POINTER_IN,
    input  wire logic [`BYTE_W-1:0]        OFFSET_HI,
    input  wire logic [`BYTE_W-1:0]        OFFSET_LO,
    input  wire logic                      BRANCH_COND,
    input  wire logic                      BRANCH_IF_NONNULL,
    input  wire ea_gen_pkg::ptr_op_t       PTR_OP,
    input  wire logic [`BYTE_W-1:0]        PTR_LOAD_VALUE,
    output logic [`ADDR_W-1:0]             OPERAND_LOCATION,
    output logic [`ADDR_W-1:0]             INSTRUCTION_POINTER,
    output logic                           DONE,
    output logic                           ILLEGAL_MODE,
    output logic                           BRANCH_TAKEN,
    output logic                           ZERO_FLAG,
    output logic [`BYTE_W-1:0]             POINTER
);
    logic [`BYTE_W-1:0]  ptr_reg;
    logic [`BYTE_W-1:0]  ptr_next;
    logic                zero_reg;
    logic                zero_next;
    logic [`ADDR_W-1:0]  ptr_ext;
    logic [`ADDR_W-1:0]  offs16;
    logic [`ADDR_W-1:0]  rel_ext;
    logic [`ADDR_W-1:0]  idx16_sum;
    logic [`ADDR_W-1:0]  next_two;
    logic [`ADDR_W-1:0]  rel_sum;
    logic [`BYTE_W:0]    idx8_sum;
    logic [`ADDR_W-1:0]  loc_next;
    logic [`ADDR_W-1:0]  ip_next;
    logic                legal;
    logic                take;

    // The byte-offset sum needs one carry bit above the pointer width inside the address.
    if (`ADDR_W < `BYTE_W + 1)
    begin : g_width_check
        $error("ea_gen: address too narrow for the byte-offset carry");
    end

    // The word-offset sum needs both offset bytes to fit in the address.
    if (`ADDR_W < 2 * `BYTE_W)
    begin : g_word_check
        $error("ea_gen: address too narrow for a word offset");
    end

    // Pointer register is an eight-bit unsigned displacement.
    // pointer zero-extended
    assign ptr_ext = {{(`ADDR_W-`BYTE_W){1'b0}}, ptr_reg};
    assign offs16  = {OFFSET_HI, OFFSET_LO};
    assign rel_ext = {{(`ADDR_W-`BYTE_W){OFFSET_LO[`BYTE_W-1]}}, OFFSET_LO};
    assign idx8_sum = {1'b0, OFFSET_LO} + {1'b0, ptr_reg};
    assign next_two = INSTR_POINTER_IN + `LEN_TWO;

    ea_adder
    #(
        .WIDTH (`ADDR_W)
    )
    u_idx16_add
    (
        .a   (offs16),
        .b   (ptr_ext),
        .sum (idx16_sum)
    );

    ea_adder
    #(
        .WIDTH (`ADDR_W)
    )
    u_rel_add
    (
        .a   (next_two),
        .b   (rel_ext),
        .sum (rel_sum)
    );

    always_comb
    begin
        unique case (MODE)
            ea_gen_pkg::MODE_IDX0,
            ea_gen_pkg::MODE_IDX8:
                legal = (INSTR_CLASS == ea_gen_pkg::CLASS_REGMEM) || (INSTR_CLASS == ea_gen_pkg::CLASS_RMW);
            ea_gen_pkg::MODE_IDX16:
                legal = (INSTR_CLASS == ea_gen_pkg::CLASS_REGMEM);
            ea_gen_pkg::MODE_REL:
                legal = (INSTR_CLASS == ea_gen_pkg::CLASS_BRANCH);
            default:
                legal = 1'b0;
        endcase
    end

    always_comb
    begin
        if (BRANCH_IF_NONNULL)
            take = !zero_reg;
        else
            take = BRANCH_COND;
    end

    always_comb
    begin
        loc_next = `ADDR_ZERO;
        ip_next  = INSTR_POINTER_IN;
        unique case (MODE)
            ea_gen_pkg::MODE_IDX0:
            begin
                loc_next = ptr_ext + `ADDR_ZERO;
                ip_next  = INSTR_POINTER_IN + `LEN_ONE;
            end
            ea_gen_pkg::MODE_IDX8:
            begin
                loc_next = {{(`ADDR_W-`BYTE_W-1){1'b0}}, idx8_sum} + `ADDR_ZERO;
                ip_next  = next_two;
            end
            ea_gen_pkg::MODE_IDX16:
            begin
                loc_next = idx16_sum;
                ip_next  = INSTR_POINTER_IN + `LEN_THREE;
            end
            ea_gen_pkg::MODE_REL:
            begin
                loc_next = rel_sum;
                ip_next  = take ? rel_sum : next_two;
            end
            default:
            begin
                loc_next = `ADDR_ZERO;
                ip_next  = INSTR_POINTER_IN;
            end
        endcase
    end

    always_comb
    begin
        ptr_next  = ptr_reg;
        zero_next = zero_reg;
        unique case (PTR_OP)
            ea_gen_pkg::PTR_LOAD:
            begin
                ptr_next  = PTR_LOAD_VALUE;
                zero_next = (PTR_LOAD_VALUE == `PTR_RESET);
            end
            ea_gen_pkg::PTR_DEC:
            begin
                ptr_next  = ptr_reg - `PTR_STEP;
                zero_next = (ptr_reg == `PTR_STEP);
            end
            default:
            begin
                ptr_next  = ptr_reg;
                zero_next = zero_reg;
            end
        endcase
    end

    // Pointer register; the branch condition reads the zero flag register before this edge's update, not this one.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            ptr_reg <= `PTR_RESET;
        end
        else
        begin
            ptr_reg <= ptr_next;
        end
    end

    // Zero flag register, kept apart from the pointer so each has one concern.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            zero_reg <= `ZERO_RESET;
        end
        else
        begin
            zero_reg <= zero_next;
        end
    end

    // Completion pulse follows every request, legal or not.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            DONE <= 1'b0;
        end
        else
        begin
            DONE <= START;
        end
    end

    // Refusal pulse stands with the completion pulse for one cycle.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            ILLEGAL_MODE <= 1'b0;
        end
        else
        begin
            ILLEGAL_MODE <= START && !legal;
        end
    end

    // Taken pulse is raised only for an accepted relative request whose condition holds.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            BRANCH_TAKEN <= 1'b0;
        end
        else
        begin
            BRANCH_TAKEN <= START && legal && (MODE == ea_gen_pkg::MODE_REL) && take;
        end
    end

    // Addresses change only on an accepted request, so a refused one leaves the last result standing.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            OPERAND_LOCATION    <= `ADDR_ZERO;
            INSTRUCTION_POINTER <= `PC_RESET;
        end
        else if (START && legal)
        begin
            OPERAND_LOCATION    <= loc_next;
            INSTRUCTION_POINTER <= ip_next;
        end
    end

    // Visible zero flag is a registered copy, equal to the internal one every cycle.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            ZERO_FLAG <= `ZERO_RESET;
        end
        else
        begin
            ZERO_FLAG <= zero_next;
        end
    end

    // Visible pointer is a registered copy, so the output comes straight from a flip-flop.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            POINTER <= `PTR_RESET;
        end
        else
        begin
            POINTER <= ptr_next;
        end
    end
endmodule // ea_gen

// >>> ea_gen_cfg.svh
// Constants for the indexed and relative operand location generator.
`ifndef EA_GEN_CFG_SVH
`define EA_GEN_CFG_SVH
`define ADDR_W          16
`define BYTE_W          8
`define PTR_RESET       8'h00
`define PC_RESET        16'h0000
`define ADDR_ZERO       16'h0000
`define LEN_ONE         16'h0001
`define LEN_TWO         16'h0002
`define LEN_THREE       16'h0003
`define ZERO_RESET      1'b0
`define PTR_STEP        8'h01
`define OFFS8_LIMIT     16'h01FE
`endif

// >>> ea_gen_pkg.sv
// Types shared by the operand location generator.
package ea_gen_pkg;
    typedef enum logic [2:0]
    {
        MODE_IDX0,
        MODE_IDX8,
        MODE_IDX16,
        MODE_REL,
        MODE_NONE
    } addr_mode_t;

    typedef enum logic [1:0]
    {
        CLASS_REGMEM,
        CLASS_RMW,
        CLASS_BRANCH,
        CLASS_OTHER
    } instr_class_t;

    typedef enum logic [1:0]
    {
        PTR_HOLD,
        PTR_LOAD,
        PTR_DEC
    } ptr_op_t;
endpackage

// >>> ea_gen_props.sv
// Checker for the operand location generator.
module ea_gen_props
(
    input wire logic                     SYS_CLK,
    input wire logic                     RESET,
    input wire logic                     START,
    input wire ea_gen_pkg::addr_mode_t   MODE,
    input wire ea_gen_pkg::instr_class_t INSTR_CLASS,
    input wire logic [15:0]              INSTR_POINTER_IN,
    input wire logic [7:0]               OFFSET_HI,
    input wire logic [7:0]               OFFSET_LO,
    input wire logic                     BRANCH_IF_NONNULL,
    input wire ea_gen_pkg::ptr_op_t      PTR_OP,
    input wire logic [15:0]              OPERAND_LOCATION,
    input wire logic [15:0]              INSTRUCTION_POINTER,
    input wire logic                     DONE,
    input wire logic                     ILLEGAL_MODE,
    input wire logic                     BRANCH_TAKEN,
    input wire logic                     ZERO_FLAG,
    input wire logic [7:0]               POINTER
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    logic mc;
    assign mc = INSTR_CLASS == ea_gen_pkg::CLASS_REGMEM || INSTR_CLASS == ea_gen_pkg::CLASS_RMW;
    sequence s_i0; START && mc && MODE == ea_gen_pkg::MODE_IDX0; endsequence
    sequence s_i8; START && mc && MODE == ea_gen_pkg::MODE_IDX8; endsequence
    sequence s_rel; START && MODE == ea_gen_pkg::MODE_REL && INSTR_CLASS == ea_gen_pkg::CLASS_BRANCH; endsequence
    a_done_follows: assert property (START |=> DONE)
        else $error("done missing");
    a_idx0_loc: assert property (s_i0 |=> OPERAND_LOCATION == {8'h00, $past(POINTER)})
        else $error("idx0 location");
    a_idx8_loc: assert property (s_i8 |=> OPERAND_LOCATION == 16'($past(OFFSET_LO)) + 16'($past(POINTER)))
        else $error("idx8 location");
    a_idx16_loc: assert property (START && MODE == ea_gen_pkg::MODE_IDX16 && INSTR_CLASS == ea_gen_pkg::CLASS_REGMEM
        |=> OPERAND_LOCATION == {$past(OFFSET_HI), $past(OFFSET_LO)} + 16'($past(POINTER)))
        else $error("idx16 location");
    a_idx16_refuse: assert property (START && MODE == ea_gen_pkg::MODE_IDX16 && !(INSTR_CLASS == 
        ea_gen_pkg::CLASS_REGMEM) |=> ILLEGAL_MODE && $stable(OPERAND_LOCATION))
        else $error("idx16 accepted");
    a_rel_target: assert property (s_rel |=> OPERAND_LOCATION == $past(INSTR_POINTER_IN) + 16'h0002
        + 16'(signed'($past(OFFSET_LO))))
        else $error("branch target");
    a_rel_choice: assert property (s_rel |=> INSTRUCTION_POINTER == (BRANCH_TAKEN ? OPERAND_LOCATION :
        $past(INSTR_POINTER_IN) + 16'h0002))
        else $error("branch pointer");
    a_nonnull_cond: assert property (s_rel ##0 BRANCH_IF_NONNULL |=> BRANCH_TAKEN == !$past(ZERO_FLAG))
        else $error("nonnull condition");
    a_dec_zero: assert property (PTR_OP == ea_gen_pkg::PTR_DEC |=> POINTER == $past(POINTER) - 8'h01
        && ZERO_FLAG == ($past(POINTER) == 8'h01))
        else $error("decrement flag");
endmodule // ea_gen_props
bind ea_gen ea_gen_props u_props (.*);

// >>> prog_mem.sv
// Program memory that feeds the offset bytes following each opcode.
module prog_mem
(
    input  wire logic [15:0]            ip,
    input  wire ea_gen_pkg::addr_mode_t mode,
    output logic [7:0]                  hi,
    output logic [7:0]                  lo
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    assign hi = mem[ip + 16'h0001];
    assign lo = (mode == ea_gen_pkg::MODE_IDX16) ? mem[ip + 16'h0002] : hi;
endmodule // prog_mem

// >>> tb.sv
// Self-checking bench for the operand location generator.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, reset = 1, start = 0, cond = 0, nonnull = 0, done, ill, taken, zf;
    ea_gen_pkg::addr_mode_t mode = ea_gen_pkg::MODE_NONE;
    ea_gen_pkg::instr_class_t cls = ea_gen_pkg::CLASS_OTHER;
    ea_gen_pkg::ptr_op_t pop = ea_gen_pkg::PTR_HOLD;
    logic [15:0] ip = 16'h0000, loc, nip;
    logic [7:0] hi, lo, pval = 8'h00, ptr;
    int fail_count = 0, num_checks = 0, cycles = 0;
    prog_mem P (.ip(ip), .mode(mode), .hi(hi), .lo(lo));
    ea_gen DUT (.SYS_CLK(sys_clk), .RESET(reset), .START(start), .MODE(mode), .INSTR_CLASS(cls),
        .INSTR_POINTER_IN(ip), .OFFSET_HI(hi), .OFFSET_LO(lo), .BRANCH_COND(cond), .BRANCH_IF_NONNULL(nonnull),
        .PTR_OP(pop), .PTR_LOAD_VALUE(pval), .OPERAND_LOCATION(loc), .INSTRUCTION_POINTER(nip), .DONE(done),
        .ILLEGAL_MODE(ill), .BRANCH_TAKEN(taken), .ZERO_FLAG(zf), .POINTER(ptr));
    initial forever #10 sys_clk = ~sys_clk;
    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task step;
        @(posedge sys_clk);
        #1;
    endtask
    task req(input ea_gen_pkg::addr_mode_t m, input ea_gen_pkg::instr_class_t c, input logic [15:0] a,
        input logic e_ill, input logic e_taken);
        mode = m;
        cls = c;
        ip = a;
        start = 1;
        step;
        check(done, 1'b1);
        check(ill, e_ill);
        check(taken, e_taken);
        start = 0;
        step;
    endtask
    task ptr_cmd(input ea_gen_pkg::ptr_op_t o, input logic [7:0] v);
        pop = o;
        pval = v;
        step;
        pop = ea_gen_pkg::PTR_HOLD;
        step;
    endtask
    task t_index;
        ptr_cmd(ea_gen_pkg::PTR_LOAD, 8'hFF);
        P.mem[16'h01FF] = 8'hFF;
        req(ea_gen_pkg::MODE_IDX8, ea_gen_pkg::CLASS_RMW, 16'h01FE, 1'b0, 1'b0);
        check(loc, 16'h01FE);
        check(nip, 16'h0200);
        req(ea_gen_pkg::MODE_IDX0, ea_gen_pkg::CLASS_REGMEM, 16'h1234, 1'b0, 1'b0);
        check(loc, 16'h00FF);
        check(nip, 16'h1235);
        P.mem[16'hFFF1] = 8'hFF;
        P.mem[16'hFFF2] = 8'hF0;
        req(ea_gen_pkg::MODE_IDX16, ea_gen_pkg::CLASS_REGMEM, 16'hFFF0, 1'b0, 1'b0);
        check(loc, 16'h00EF);
        check(nip, 16'hFFF3);
        $display("index test done");
    endtask
    task refuse(input ea_gen_pkg::addr_mode_t m, input ea_gen_pkg::instr_class_t c);
        req(m, c, 16'h0300, 1'b1, 1'b0);
        check(nip, 16'hFFF3);
        check(loc, 16'h00EF);
    endtask
    task branch(input logic [15:0] a, input logic [7:0] off, input logic [15:0] t, input logic [15:0] n,
        input logic e_taken);
        P.mem[a + 16'h0001] = off;
        req(ea_gen_pkg::MODE_REL, ea_gen_pkg::CLASS_BRANCH, a, 1'b0, e_taken);
        check(loc, t);
        check(nip, n);
    endtask
    task t_branch;
        nonnull = 1;
        ptr_cmd(ea_gen_pkg::PTR_LOAD, 8'h01);
        ptr_cmd(ea_gen_pkg::PTR_DEC, 8'h00);
        check(zf, 1'b1);
        branch(16'h04A7, 8'hFA, 16'h04A3, 16'h04A9, 1'b0);
        check(ptr, 8'h00);
        ptr_cmd(ea_gen_pkg::PTR_LOAD, 8'h02);
        ptr_cmd(ea_gen_pkg::PTR_DEC, 8'h00);
        branch(16'h04A7, 8'hFA, 16'h04A3, 16'h04A3, 1'b1);
        check(ptr, 8'h01);
        nonnull = 0;
        cond = 1;
        branch(16'hFFFE, 8'h7F, 16'h007F, 16'h007F, 1'b1);
        branch(16'h0200, 8'h00, 16'h0202, 16'h0202, 1'b1);
        cond = 0;
        branch(16'h0200, 8'h10, 16'h0212, 16'h0202, 1'b0);
        $display("branch test done");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            fail_count++;
            stop_test;
        end
    end
    initial
    begin
        repeat (16) step;
        reset = 0;
        check(loc, 16'h0000);
        check(zf, 1'b0);
        t_index;
        refuse(ea_gen_pkg::MODE_IDX16, ea_gen_pkg::CLASS_RMW);
        refuse(ea_gen_pkg::MODE_REL, ea_gen_pkg::CLASS_REGMEM);
        refuse(ea_gen_pkg::MODE_IDX0, ea_gen_pkg::CLASS_BRANCH);
        refuse(ea_gen_pkg::MODE_NONE, ea_gen_pkg::CLASS_REGMEM);
        $display("refusal test done");
        t_branch;
        stop_test;
    end
endmodule // tb
